// ### hdl/mpsm_ms_tick.v
// Millisecond tick generator from the system clock
`timescale 1ns/1ns
`include "mpsm_consts.vh"
module mpsm_ms_tick #(
  parameter integer DIV = `MPSM_CYC_PER_MS
) (
  // Clock and reset
  input  wire clk,
  input  wire resetn,
  input  wire clk_en,
  // Tick out
  output reg  tick_q
);
  reg [31:0] cnt_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (cnt_q >= DIV - 1) begin
        cnt_q  <= 32'h0;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 32'h1;
        tick_q <= 1'b0;
      end
    end
  end
endmodule

// ### hdl/mpsm_power_manager.v
// Power state manager of the optical motion sensor
`timescale 1ns/1ns
`include "mpsm_consts.vh"
// What this block does
// RULE1: In manual mode releasing the sleep request pin wakes the sensor, analog then DC/DC.
// RULE2: A manual wake runs a single frame so the pin may be released at once.
// RULE3: In automatic mode the controller keeps the sleep request pin high after init.
// RULE4: Each low-power state takes one frame, reloads its wake timer and sleeps again.
// RULE5: The motion-ready output is high while motion data waits to be polled.
// RULE6: The sensor stays running until all pending motion data has been read.
// RULE7: While running the frame rate is 1K below 7 ips, 2K from 7 to 14, 4K above 14.
// RULE8: The sensor stays running while it keeps seeing motion.
// RULE9: After 50 ms without motion the sensor drops to the first doze state.
// RULE10: First doze wakes one frame every 10 ms, running on motion, dozing otherwise.
// RULE11: After 8 s in first doze it moves to second doze, waking every 100 ms.
// RULE12: After 10 min without activity it sleeps, waking every 500 ms.
// RULE13: In automatic mode the controller may stand by until motion-ready rises.
// RULE14: Motion in a second-doze or sleep wake frame returns straight to running.
module mpsm_power_manager #(
  parameter integer MS_DIV      = `MPSM_CYC_PER_MS,
  parameter integer RUN_IDLE_MS = `MPSM_RUN_IDLE_MS,
  parameter integer D1_PER_MS   = `MPSM_DOZE1_PERIOD_MS,
  parameter integer D1_SPAN_MS  = `MPSM_DOZE1_SPAN_MS,
  parameter integer D2_PER_MS   = `MPSM_DOZE2_PERIOD_MS,
  parameter integer SL_SPAN_MS  = `MPSM_SLEEP_SPAN_MS,
  parameter integer SL_PER_MS   = `MPSM_SLEEP_PERIOD_MS,
  parameter integer VEL_W       = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             resetn,
  input  wire             clk_en,
  // Pin and mode
  input  wire             sleep_request_pin,
  input  wire             auto_mode,
  // Motion engine
  input  wire             frame_done,
  input  wire             motion_seen,
  input  wire [VEL_W-1:0] velocity_ips,
  input  wire             data_read,
  // Outputs
  output reg  [1:0]       engine_en_q,
  output reg              frame_req_q,
  output reg  [1:0]       frame_rate_q,
  output reg              motion_ready_q,
  output reg  [2:0]       state_q,
  output reg  [31:0]      wake_timer_q
);
  reg        pin_s1_q;
  reg        pin_s2_q;
  reg [31:0] idle_ms_q;
  reg [2:0]  ret_q;
  reg        pend_q;
  reg        motion_d;
  wire       ms_tick;

  mpsm_ms_tick #(.DIV(MS_DIV)) u_tick (
    .clk    (clk),
    .resetn (resetn),
    .clk_en (clk_en),
    .tick_q (ms_tick)
  );

  // Pin comes from the controller domain
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end else if (clk_en) begin
      pin_s1_q <= sleep_request_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Frame rate tracks velocity only while running
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_rate_q <= `MPSM_RATE_1K;
    end else if (clk_en && state_q == `MPSM_ST_RUN) begin
      if (velocity_ips > `MPSM_FAST_IPS)
        frame_rate_q <= `MPSM_RATE_4K; // [RULE7]
      else if (velocity_ips >= `MPSM_SLOW_IPS)
        frame_rate_q <= `MPSM_RATE_2K; // [RULE7]
      else
        frame_rate_q <= `MPSM_RATE_1K; // [RULE7]
    end
  end

  // Pending data: new motion wins over a read in the same cycle
  always @* begin
    motion_d = frame_done && motion_seen;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_q         <= 1'b0;
      motion_ready_q <= 1'b0;
    end else if (clk_en) begin
      if (motion_d)
        pend_q <= 1'b1; // [RULE5]
      else if (data_read)
        pend_q <= 1'b0;
      motion_ready_q <= motion_d | (pend_q & ~data_read); // [RULE5]
    end
  end

  // Main sequencer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= `MPSM_ST_OFF;
      ret_q        <= `MPSM_ST_DOZE1;
      engine_en_q  <= 2'h0;
      frame_req_q  <= 1'b0;
      idle_ms_q    <= 32'h0;
      wake_timer_q <= 32'h0;
    end else if (clk_en) begin
      frame_req_q <= 1'b0;
      if (ms_tick && wake_timer_q != 32'h0)
        wake_timer_q <= wake_timer_q - 32'h1;
      if (ms_tick)
        idle_ms_q <= idle_ms_q + 32'h1;
      case (state_q)
        `MPSM_ST_OFF: begin
          engine_en_q <= 2'h0;
          // Manual wake on pin release; automatic mode starts at init
          if (!pin_s2_q || auto_mode) begin
            engine_en_q <= `MPSM_ENG_ANALOG; // [RULE1]
            state_q     <= `MPSM_ST_POWERUP;
          end
        end
        `MPSM_ST_POWERUP: begin
          engine_en_q <= `MPSM_ENG_ALL; // [RULE1]
          frame_req_q <= 1'b1;
          idle_ms_q   <= 32'h0;
          if (auto_mode)
            state_q <= `MPSM_ST_RUN;
          else
            state_q <= `MPSM_ST_WAKE; // [RULE2]
        end
        `MPSM_ST_WAKE: begin
          // One frame only, then running on motion in automatic mode, else back to the resting state
          if (frame_done) begin
            engine_en_q <= 2'h0;
            if (auto_mode && motion_seen) begin
              engine_en_q <= `MPSM_ENG_ALL;
              idle_ms_q   <= 32'h0;
              state_q     <= `MPSM_ST_RUN; // [RULE10] [RULE14]
            end else if (auto_mode) begin
              state_q <= ret_q; // [RULE4]
            end else begin
              state_q <= `MPSM_ST_OFF; // [RULE2]
            end
          end
        end
        `MPSM_ST_RUN: begin
          if (!auto_mode) begin
            engine_en_q <= 2'h0;
            state_q     <= `MPSM_ST_OFF;
          end else begin
            frame_req_q <= 1'b1;
            if (motion_d || pend_q || motion_ready_q)
              idle_ms_q <= 32'h0; // [RULE6] [RULE8]
            else if (idle_ms_q >= RUN_IDLE_MS) begin
              engine_en_q  <= 2'h0;
              idle_ms_q    <= 32'h0;
              wake_timer_q <= D1_PER_MS; // [RULE9]
              state_q      <= `MPSM_ST_DOZE1;
            end
          end
        end
        default: begin
          // Doze and sleep: wait for the wake timer, then one frame
          if (!auto_mode) begin
            state_q <= `MPSM_ST_OFF;
          end else if (state_q == `MPSM_ST_DOZE1 && idle_ms_q >= D1_SPAN_MS) begin
            wake_timer_q <= D2_PER_MS; // [RULE11]
            state_q      <= `MPSM_ST_DOZE2;
          end else if (state_q == `MPSM_ST_DOZE2 &&
                       idle_ms_q >= SL_SPAN_MS - RUN_IDLE_MS) begin
            wake_timer_q <= SL_PER_MS; // [RULE12]
            state_q      <= `MPSM_ST_SLEEP;
          end else if (wake_timer_q == 32'h0 && state_q != `MPSM_ST_OFF) begin
            ret_q       <= state_q;
            engine_en_q <= `MPSM_ENG_ALL;
            frame_req_q <= 1'b1;
            state_q     <= `MPSM_ST_WAKE;
            if (state_q == `MPSM_ST_DOZE1)
              wake_timer_q <= D1_PER_MS; // [RULE4] [RULE10]
            else if (state_q == `MPSM_ST_DOZE2)
              wake_timer_q <= D2_PER_MS; // [RULE4] [RULE11]
            else
              wake_timer_q <= SL_PER_MS; // [RULE4] [RULE12]
          end
        end
      endcase
    end
  end
endmodule

// ### shared/mpsm_consts.vh
// Timing, state and rate constants for the motion power state manager
`ifndef MPSM_CONSTS_VH
`define MPSM_CONSTS_VH
`define MPSM_CLK_HZ          100000000
`define MPSM_RUN_IDLE_MS     50
`define MPSM_DOZE1_PERIOD_MS 10
`define MPSM_DOZE1_SPAN_MS   8000
`define MPSM_DOZE2_PERIOD_MS 100
`define MPSM_SLEEP_SPAN_MS   600000
`define MPSM_SLEEP_PERIOD_MS 500
`define MPSM_CYC_PER_MS      (`MPSM_CLK_HZ / 1000)
`define MPSM_SLOW_IPS        7
`define MPSM_FAST_IPS        14
`define MPSM_ST_OFF          3'h0
`define MPSM_ST_POWERUP      3'h1
`define MPSM_ST_RUN          3'h2
`define MPSM_ST_DOZE1        3'h3
`define MPSM_ST_DOZE2        3'h4
`define MPSM_ST_SLEEP        3'h5
`define MPSM_ST_WAKE         3'h6
`define MPSM_RATE_1K         2'h0
`define MPSM_RATE_2K         2'h1
`define MPSM_RATE_4K         2'h2
`define MPSM_ENG_ANALOG      2'h1
`define MPSM_ENG_ALL         2'h3
`endif

// ### sim/mpsm_checker.sv
// Port assertions for the power state manager
`timescale 1ns/1ns
`include "mpsm_consts.vh"
module mpsm_checker (
  // Clock and reset
  input wire       clk,
  input wire       resetn,
  // Inputs watched
  input wire       auto_mode,
  input wire       frame_done,
  input wire       motion_seen,
  input wire [7:0] velocity_ips,
  // Outputs watched
  input wire [1:0] engine_en_q,
  input wire       frame_req_q,
  input wire [1:0] frame_rate_q,
  input wire       motion_ready_q,
  input wire [2:0] state_q
);
  wire run = state_q == `MPSM_ST_RUN;
  wire wk  = state_q == `MPSM_ST_WAKE;
  wire mot = frame_done & motion_seen;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  pwrup_engine_a: assert property (state_q == `MPSM_ST_POWERUP |->
    engine_en_q == `MPSM_ENG_ANALOG) else $error("analog first");
  single_frame_a: assert property (!auto_mode && wk && frame_done |=>
    state_q == `MPSM_ST_OFF) else $error("manual wake not one frame");
  wake_req_a: assert property ($rose(wk) |-> ##[0:1] frame_req_q)
    else $error("no wake frame");
  ready_set_a: assert property (mot |=> motion_ready_q) else $error("ready");
  run_pending_a: assert property (auto_mode && run && motion_ready_q |=> run)
    else $error("left run with data pending");
  run_dwell_a: assert property (auto_mode && $rose(run) |-> run[*8])
    else $error("run too short");
  wake_run_a: assert property (auto_mode && wk && mot |=> run)
    else $error("motion did not wake");
  rate_pick_a: assert property (run && $past(run, 2) && $stable(velocity_ips) &&
    $past(velocity_ips, 2) == velocity_ips |-> frame_rate_q == (velocity_ips < 7 ?
    `MPSM_RATE_1K : velocity_ips > 14 ? `MPSM_RATE_4K : `MPSM_RATE_2K)) else $error("rate");
endmodule
bind mpsm_power_manager mpsm_checker u_chk (.clk(clk), .resetn(resetn),
  .auto_mode(auto_mode), .frame_done(frame_done), .motion_seen(motion_seen),
  .velocity_ips(velocity_ips), .engine_en_q(engine_en_q), .frame_req_q(frame_req_q),
  .frame_rate_q(frame_rate_q), .motion_ready_q(motion_ready_q), .state_q(state_q));

// ### sim/mpsm_mcu_model.sv
// Companion controller model: pin control and motion polling
`timescale 1ns/1ns
module mpsm_mcu_model (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Control
  input  wire       auto_mode,
  input  wire       wake_cmd,
  input  wire [3:0] lat,
  // Sensor side
  input  wire       motion_ready_q,
  output reg        sleep_request_pin,
  output reg        data_read
);
  reg [3:0] cnt_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_request_pin <= 1'b1;
      data_read         <= 1'b0;
      cnt_q             <= 4'h0;
    end else begin
      sleep_request_pin <= auto_mode | ~wake_cmd;
      data_read         <= 1'b0;
      cnt_q             <= motion_ready_q ? cnt_q + 4'h1 : 4'h0;
      // Poll only after ready rises, lat cycles late
      if (motion_ready_q && cnt_q == lat) begin
        data_read <= 1'b1;
        cnt_q     <= 4'h0;
      end
    end
  end
endmodule

// ### sim/mpsm_power_manager_tb.sv
// Testbench for the power state manager
`timescale 1ns/1ns
`include "mpsm_consts.vh"
module mpsm_power_manager_tb;
  reg         clk = 0, resetn = 0, auto_mode = 0, wake_cmd = 0, mot_q = 0;
  reg         frame_done = 0, motion_seen = 0, clk_en = 1;
  reg  [7:0]  velocity_ips = 8'h00;
  reg  [3:0]  lat = 4'h0;
  reg  [31:0] vt = 32'h0F0E0706;
  reg  [7:0]  rt = 8'h94;
  wire        sleep_request_pin, data_read, frame_req_q, motion_ready_q;
  wire [1:0]  engine_en_q, frame_rate_q;
  wire [2:0]  state_q;
  integer     num_errors = 0, checks_done = 0, cyc = 0, n, i;
  // Run idle and first doze period keep their real values
  mpsm_power_manager #(.MS_DIV(2), .D1_SPAN_MS(25),
    .D2_PER_MS(4), .SL_SPAN_MS(110), .SL_PER_MS(6)) dut (.clk(clk),
    .resetn(resetn), .clk_en(clk_en), .sleep_request_pin(sleep_request_pin),
    .auto_mode(auto_mode), .frame_done(frame_done), .motion_seen(motion_seen),
    .velocity_ips(velocity_ips), .data_read(data_read), .engine_en_q(engine_en_q),
    .frame_req_q(frame_req_q), .frame_rate_q(frame_rate_q),
    .motion_ready_q(motion_ready_q), .state_q(state_q), .wake_timer_q());
  mpsm_mcu_model mcu (.clk(clk), .resetn(resetn), .auto_mode(auto_mode),
    .wake_cmd(wake_cmd), .lat(lat), .motion_ready_q(motion_ready_q),
    .sleep_request_pin(sleep_request_pin), .data_read(data_read));
  initial forever #5 clk = ~clk;
  // Frame engine answers a request one cycle later, unless it answered one the cycle before
  always @(posedge clk) begin
    frame_done  <= frame_req_q & ~frame_done;
    motion_seen <= frame_req_q & mot_q;
    cyc = cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
      end
    end
  endtask
  // Cycles spent waiting land in n
  task wait_st(input [2:0] s);
    begin
      n = 0;
      while (state_q !== s && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task t_manual;
    begin
      @(posedge clk) begin
        clk_en   <= 0;
        wake_cmd <= 1;
      end
      repeat (6) @(negedge clk);
      chk(state_q, `MPSM_ST_OFF);
      @(posedge clk) clk_en <= 1;
      wait_st(`MPSM_ST_POWERUP);
      chk(engine_en_q, `MPSM_ENG_ANALOG);
      @(posedge clk) wake_cmd <= 0;
      wait_st(`MPSM_ST_WAKE);
      chk(engine_en_q, `MPSM_ENG_ALL);
      wait_st(`MPSM_ST_OFF);
      chk(n < 5, 1);
    end
  endtask
  task t_auto;
    begin
      @(posedge clk) auto_mode <= 1;
      mot_q <= 1;
      wait_st(`MPSM_ST_RUN);
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk) velocity_ips <= vt[8*i+:8];
        repeat (4) @(negedge clk);
        chk(frame_rate_q, rt[2*i+:2]);
      end
      @(posedge clk) lat <= 4'hF;
      mot_q <= 0;
      repeat (14) @(negedge clk);
      chk(motion_ready_q, 1);
      chk(state_q, `MPSM_ST_RUN);
      wait_st(`MPSM_ST_DOZE1);
      chk(n >= 100 && n <= 112, 1);
      wait_st(`MPSM_ST_WAKE);
      chk(n >= 18 && n <= 24, 1);
      wait_st(`MPSM_ST_DOZE1);
      chk(state_q, `MPSM_ST_DOZE1);
      wait_st(`MPSM_ST_DOZE2);
      chk(n >= 20 && n <= 34, 1);
      wait_st(`MPSM_ST_WAKE);
      wait_st(`MPSM_ST_DOZE2);
      wait_st(`MPSM_ST_WAKE);
      chk(n >= 6 && n <= 10, 1);
      wait_st(`MPSM_ST_SLEEP);
      chk(state_q, `MPSM_ST_SLEEP);
      wait_st(`MPSM_ST_WAKE);
      wait_st(`MPSM_ST_SLEEP);
      @(posedge clk) mot_q <= 1;
      wait_st(`MPSM_ST_RUN);
      chk(n >= 9 && n <= 15, 1);
    end
  endtask
  task give_verdict;
    begin
      if (num_errors == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1;
    t_manual;
    t_auto;
    give_verdict;
  end
endmodule
